// ### verilog/mpt_pkg.sv
/*
 * Shared constants, types and helpers of the memory pattern tester.
 * Assumes one clock domain. The memory under test is a single-port
 * synchronous RAM with one cycle of read latency.
 */
package mpt_pkg;

    // ------------------------------------------------------------
    // Widths and carriers
    // ------------------------------------------------------------
    localparam int AW = 16;
    localparam int DW = 16;
    typedef logic [AW-1:0] addr_t;
    typedef logic [DW-1:0] data_t;

    // Request to the memory under test
    typedef struct packed {
        logic  re;
        logic  we;
        addr_t addr;
        data_t wdata;
    } mem_req_t;

    // ------------------------------------------------------------
    // Register offsets and fields
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL      = 8'h00;
    localparam logic [7:0] OFF_CFG       = 8'h04;
    localparam logic [7:0] OFF_RANGE     = 8'h08;
    localparam logic [7:0] OFF_STATUS    = 8'h0c;
    localparam logic [7:0] OFF_IRQ_STAT  = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK  = 8'h14;
    localparam logic [7:0] OFF_FAIL_ADDR = 8'h18;
    localparam logic [7:0] OFF_FAIL_DATA = 8'h1c;
    localparam logic [7:0] OFF_REPORT    = 8'h20;
    localparam int CTRL_RUN_BIT  = 0;
    localparam int CTRL_STOP_BIT = 1;
    localparam int CFG_MODE_BIT  = 4;
    localparam int IRQ_PASS = 0;
    localparam int IRQ_ERR  = 1;
    localparam int IRQ_DONE = 2;
    localparam int IRQ_CFG  = 3;

    // ------------------------------------------------------------
    // Reset values and patterns
    // ------------------------------------------------------------
    localparam logic [3:0] CFG_SEL_RST  = 4'hf;
    localparam logic       CFG_CONT_RST = 1'b0;
    localparam addr_t      RANGE_LO_RST = 16'h0000;
    localparam addr_t      RANGE_HI_RST = 16'hffff;
    localparam data_t      WORD_VALUE   = 16'h00ff;
    localparam data_t      GAL_BG_P1    = 16'haaaa;
    localparam data_t      GAL_TW_P1    = 16'h5555;
    localparam addr_t      GAL_SPAN     = 16'h03ff;

    // Fixed segment ends, ascending
    localparam addr_t SEG_ENDS [7] = '{16'h0fff, 16'h3fff, 16'h9fff,
        16'hafff, 16'hdbff, 16'hdfff, 16'hffff};

    // Test indices, in run order
    localparam logic [2:0] TEST_ADDR = 3'h0;
    localparam logic [2:0] TEST_WORD = 3'h1;
    localparam logic [2:0] TEST_BIT  = 3'h2;
    localparam logic [2:0] TEST_GAL  = 3'h3;
    localparam logic [2:0] TEST_NONE = 3'h4;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic addr_t seg_end(addr_t a);
        addr_t e;
        e = SEG_ENDS[6];
        for (int i = 6; i >= 0; i--) begin
            if (a <= SEG_ENDS[i]) e = SEG_ENDS[i];
        end
        return e;
    endfunction

    function automatic addr_t amin(addr_t a, addr_t b);
        return (a < b) ? a : b;
    endfunction

    function automatic logic [2:0] next_test(logic [3:0] sel,
                                             logic [2:0] from);
        logic [2:0] r;
        r = TEST_NONE;
        for (int i = 3; i >= 0; i--) begin
            if (sel[i] && 3'(i) >= from) r = 3'(i);
        end
        return r;
    endfunction

    // Word or bit test value for step 0, 1 (complement) or 2
    function automatic data_t pattern(logic [2:0] t, logic [1:0] step,
                                      data_t mask);
        data_t b;
        b = (t == TEST_BIT) ? mask : WORD_VALUE;
        return (step == 2'h1) ? ~b : b;
    endfunction

    // Galloping word: second pass swaps background and test word
    function automatic data_t gal_word(logic pass, logic test_word);
        return (pass ^ test_word) ? GAL_TW_P1 : GAL_BG_P1;
    endfunction

endpackage

// ### verilog/memory_pattern_tester.sv
/*
 * Memory pattern tester: address, word, bit and galloping tests over
 * a range of memory, with an APB register slave and one interrupt.
 * Assumes the memory and the APB master share CLK_I; the memory
 * returns read data in the cycle after the request cycle.
 */
// The APB register port and the placing of the registers were left to the implementer.
// How it works
// - Address test writes then checks own address
// - Word test: value, complement, value, each verified
// - Word test runs twice over range
// - Bit test uses walking one-hot mask
// - Galloping fills background, then places test word
// - Each background read followed by test-word read
// - Restore, move test word until range covered
// - Second galloping pass swaps the two patterns
// - Address/word/bit run per fixed segment, reported
// - Galloping runs in one-kiloword chunks
// - Only selected tests run
// - Continuous mode cycles segments until stopped
// - Halt mode stops on error or range end
// - Illegal settings rejected, previous kept
// - Failure keeps address, expected and read word
module memory_pattern_tester (
    input  wire logic             CLK_I,
    input  wire logic             RST_N_I,
    input  wire logic             CE_I,
    input  wire logic             PSEL_I,
    input  wire logic             PENABLE_I,
    input  wire logic             PWRITE_I,
    input  wire logic [7:0]       PADDR_I,
    input  wire logic [31:0]      PWDATA_I,
    output logic      [31:0]      PRDATA_O,
    output logic                  PREADY_O,
    output logic                  PSLVERR_O,
    output mpt_pkg::mem_req_t     MEM_REQ_O,
    input  wire mpt_pkg::data_t   MEM_RDATA_I,
    output logic                  IRQ_O
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        S_IDLE, S_SEG, S_TEST, S_A_WR, S_A_RD, S_A_ADV,
        S_WB_WR, S_WB_RD, S_WB_ADV, S_G_FILL, S_G_FV, S_G_FV_ADV,
        S_G_PUT, S_G_BG, S_G_TW, S_G_ADV, S_G_REST, S_G_NEXT,
        S_WAIT, S_CHK, S_TDONE, S_REPORT, S_SEG_END
    } phase_t;

    typedef struct packed {
        phase_t            st;
        phase_t            ret;
        logic [2:0]        test;
        logic              pass;
        logic [1:0]        step;
        mpt_pkg::data_t    mask;
        mpt_pkg::addr_t    addr;
        mpt_pkg::addr_t    tloc;
        mpt_pkg::addr_t    lo;
        mpt_pkg::addr_t    hi;
        mpt_pkg::addr_t    seg_lo;
        mpt_pkg::addr_t    seg_hi;
        mpt_pkg::addr_t    raddr;
        mpt_pkg::data_t    exp;
        logic [3:0]        cfg_sel;
        logic              cfg_cont;
        mpt_pkg::addr_t    cfg_lo;
        mpt_pkg::addr_t    cfg_hi;
        logic [3:0]        run_sel;
        logic              run_cont;
        mpt_pkg::addr_t    run_lo;
        mpt_pkg::addr_t    run_hi;
        logic              stop_req;
        logic              fail_seen;
        logic [3:0]        irq_stat;
        logic [3:0]        irq_mask;
        mpt_pkg::addr_t    fail_addr;
        mpt_pkg::data_t    fail_exp;
        mpt_pkg::data_t    fail_act;
        mpt_pkg::addr_t    rep_lo;
        mpt_pkg::addr_t    rep_hi;
        mpt_pkg::mem_req_t mem;
        logic [31:0]       prdata;
        logic              pready;
        logic              pslverr;
        logic              irq;
    } state_t;

    state_t q;
    state_t n;

    // Queue a read; data is compared two cycles later in S_CHK
    function automatic state_t rd(state_t s, mpt_pkg::addr_t a,
                                  mpt_pkg::data_t e, phase_t r);
        s.mem.re   = 1'b1;
        s.mem.addr = a;
        s.raddr    = a;
        s.exp      = e;
        s.ret      = r;
        s.st       = S_WAIT;
        return s;
    endfunction

    function automatic state_t wr(state_t s, mpt_pkg::addr_t a,
                                  mpt_pkg::data_t d, phase_t nx);
        s.mem.we    = 1'b1;
        s.mem.addr  = a;
        s.mem.wdata = d;
        s.st        = nx;
        return s;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [3:0] ev;
        logic [3:0] w1c;
        logic       wr_en;
        logic       run;
        logic       stop;
        logic [2:0] nt;
        mpt_pkg::data_t bg;
        mpt_pkg::data_t tw;
        ev    = '0;
        w1c   = '0;
        nt    = mpt_pkg::TEST_NONE;
        n     = q;
        n.mem.re = 1'b0;
        n.mem.we = 1'b0;
        bg    = mpt_pkg::gal_word(q.pass, 1'b0);
        tw    = mpt_pkg::gal_word(q.pass, 1'b1);
        // Write lands only at the edge that completes the access
        wr_en = PSEL_I & PENABLE_I & q.pready & PWRITE_I;
        run   = wr_en && PADDR_I == mpt_pkg::OFF_CTRL
                && PWDATA_I[mpt_pkg::CTRL_RUN_BIT];
        stop  = wr_en && PADDR_I == mpt_pkg::OFF_CTRL
                && PWDATA_I[mpt_pkg::CTRL_STOP_BIT];

        // One wait state, so read data comes from a flop
        n.pready  = PSEL_I & PENABLE_I & ~q.pready;
        n.pslverr = 1'b0;
        if (n.pready) begin
            case (PADDR_I)
                mpt_pkg::OFF_CTRL:      n.prdata = '0;
                mpt_pkg::OFF_CFG:
                    n.prdata = 32'({q.cfg_cont, q.cfg_sel});
                mpt_pkg::OFF_RANGE:     n.prdata = {q.cfg_hi, q.cfg_lo};
                mpt_pkg::OFF_STATUS:
                    n.prdata = 32'({q.fail_seen, q.stop_req,
                                    q.st != S_IDLE});
                mpt_pkg::OFF_IRQ_STAT:  n.prdata = 32'(q.irq_stat);
                mpt_pkg::OFF_IRQ_MASK:  n.prdata = 32'(q.irq_mask);
                mpt_pkg::OFF_FAIL_ADDR: n.prdata = 32'(q.fail_addr);
                mpt_pkg::OFF_FAIL_DATA:
                    n.prdata = {q.fail_act, q.fail_exp};
                mpt_pkg::OFF_REPORT:    n.prdata = {q.rep_hi, q.rep_lo};
                default: begin
                    n.prdata  = '0;
                    n.pslverr = 1'b1;
                end
            endcase
        end

        // Register writes
        if (wr_en) begin
            case (PADDR_I)
                mpt_pkg::OFF_CFG: begin
                    if (PWDATA_I[3:0] != 4'h0) begin
                        n.cfg_sel  = PWDATA_I[3:0];
                        n.cfg_cont = PWDATA_I[mpt_pkg::CFG_MODE_BIT];
                    end else begin
                        ev[mpt_pkg::IRQ_CFG] = 1'b1;
                    end
                end
                mpt_pkg::OFF_RANGE: begin
                    if (PWDATA_I[15:0] <= PWDATA_I[31:16]) begin
                        n.cfg_lo = PWDATA_I[15:0];
                        n.cfg_hi = PWDATA_I[31:16];
                    end else begin
                        ev[mpt_pkg::IRQ_CFG] = 1'b1;
                    end
                end
                mpt_pkg::OFF_IRQ_STAT: w1c = PWDATA_I[3:0];
                mpt_pkg::OFF_IRQ_MASK: n.irq_mask = PWDATA_I[3:0];
                default: ;
            endcase
        end

        // stop request honoured at segment end
        if (stop && q.st != S_IDLE) n.stop_req = 1'b1;

        unique case (q.st)
            S_IDLE: begin
                if (run) begin
                    n.run_sel   = q.cfg_sel;
                    n.run_cont  = q.cfg_cont;
                    n.run_lo    = q.cfg_lo;
                    n.run_hi    = q.cfg_hi;
                    n.seg_lo    = q.cfg_lo;
                    n.stop_req  = 1'b0;
                    n.fail_seen = 1'b0;
                    n.st        = S_SEG;
                end
            end
            S_SEG: begin
                n.seg_hi = mpt_pkg::amin(mpt_pkg::seg_end(q.seg_lo),
                                         q.run_hi);
                n.lo = q.seg_lo;
                n.hi = n.seg_hi;
                nt = mpt_pkg::next_test(q.run_sel, mpt_pkg::TEST_ADDR);
                if (nt == mpt_pkg::TEST_GAL) begin
                    n.test = mpt_pkg::TEST_ADDR;
                    n.st   = S_G_NEXT;
                end else begin
                    n.test = nt;
                    n.st   = S_TEST;
                end
            end
            S_TEST: begin
                n.addr = q.lo;
                n.step = 2'h0;
                n.pass = 1'b0;
                n.mask = 16'h0001;
                if (q.test == mpt_pkg::TEST_ADDR) n.st = S_A_WR;
                else if (q.test == mpt_pkg::TEST_GAL) n.st = S_G_FILL;
                else n.st = S_WB_WR;
            end
            // store own address, then check all
            S_A_WR: begin
                n = wr(n, q.addr, q.addr, S_A_WR);
                if (q.addr == q.hi) begin
                    n.addr = q.lo;
                    n.st   = S_A_RD;
                end else begin
                    n.addr = q.addr + 1'b1;
                end
            end
            S_A_RD: n = rd(n, q.addr, q.addr, S_A_ADV);
            S_A_ADV: begin
                if (q.addr == q.hi) n.st = S_TDONE;
                else begin
                    n.addr = q.addr + 1'b1;
                    n.st   = S_A_RD;
                end
            end
            // store and verify each step in place
            S_WB_WR: n = wr(n, q.addr,
                mpt_pkg::pattern(q.test, q.step, q.mask), S_WB_RD);
            S_WB_RD: n = rd(n, q.addr,
                mpt_pkg::pattern(q.test, q.step, q.mask), S_WB_ADV);
            S_WB_ADV: begin
                n.st = S_WB_WR;
                if (q.step != 2'h2) n.step = q.step + 1'b1;
                else begin
                    n.step = 2'h0;
                    // walk the mask, then next word
                    if (q.test == mpt_pkg::TEST_BIT
                        && !q.mask[mpt_pkg::DW-1]) begin
                        n.mask = q.mask << 1;
                    end else begin
                        n.mask = 16'h0001;
                        if (q.addr != q.hi) n.addr = q.addr + 1'b1;
                        else if (!q.pass) begin
                            n.pass = 1'b1;
                            n.addr = q.lo;
                        end else n.st = S_TDONE;
                    end
                end
            end
            S_G_FILL: begin
                n = wr(n, q.addr, bg, S_G_FILL);
                if (q.addr == q.hi) begin
                    n.addr = q.lo;
                    n.st   = S_G_FV;
                end else begin
                    n.addr = q.addr + 1'b1;
                end
            end
            S_G_FV: n = rd(n, q.addr, bg, S_G_FV_ADV);
            S_G_FV_ADV: begin
                if (q.addr == q.hi) begin
                    n.tloc = q.lo;
                    n.st   = S_G_PUT;
                end else begin
                    n.addr = q.addr + 1'b1;
                    n.st   = S_G_FV;
                end
            end
            S_G_PUT: begin
                n = wr(n, q.tloc, tw, S_G_BG);
                n.addr = q.lo;
            end
            S_G_BG: begin
                if (q.addr == q.tloc) n.st = S_G_ADV;
                else n = rd(n, q.addr, bg, S_G_TW);
            end
            S_G_TW: n = rd(n, q.tloc, tw, S_G_ADV);
            S_G_ADV: begin
                if (q.addr == q.hi) n.st = S_G_REST;
                else begin
                    n.addr = q.addr + 1'b1;
                    n.st   = S_G_BG;
                end
            end
            // restore and move the test word
            S_G_REST: begin
                n = wr(n, q.tloc, bg, S_G_PUT);
                if (q.tloc != q.hi) n.tloc = q.tloc + 1'b1;
                // swap patterns for the second pass
                else if (!q.pass) begin
                    n.pass = 1'b1;
                    n.addr = q.lo;
                    n.st   = S_G_FILL;
                end else n.st = S_TDONE;
            end
            S_G_NEXT: begin
                n.lo   = (q.test == mpt_pkg::TEST_GAL)
                         ? q.hi + 1'b1 : q.seg_lo;
                n.hi   = mpt_pkg::amin(n.lo | mpt_pkg::GAL_SPAN,
                                       q.seg_hi);
                n.test = mpt_pkg::TEST_GAL;
                n.st   = S_TEST;
            end
            S_WAIT: n.st = S_CHK;
            S_CHK: begin
                if (MEM_RDATA_I != q.exp) begin
                    n.fail_addr = q.raddr;
                    n.fail_exp  = q.exp;
                    n.fail_act  = MEM_RDATA_I;
                    n.fail_seen = 1'b1;
                    ev[mpt_pkg::IRQ_ERR] = 1'b1;
                    // halt mode stops at first error
                    if (q.run_cont) n.st = S_SEG_END;
                    else begin
                        ev[mpt_pkg::IRQ_DONE] = 1'b1;
                        n.st = S_IDLE;
                    end
                end else n.st = q.ret;
            end
            S_TDONE: begin
                n.st = S_REPORT;
                if (q.test == mpt_pkg::TEST_GAL) begin
                    n.ret = (q.hi == q.seg_hi) ? S_SEG_END : S_G_NEXT;
                end else begin
                    nt = mpt_pkg::next_test(q.run_sel, q.test + 1'b1);
                    if (nt == mpt_pkg::TEST_GAL) n.ret = S_G_NEXT;
                    else if (nt == mpt_pkg::TEST_NONE) n.ret = S_SEG_END;
                    else begin
                        n.test = nt;
                        n.st   = S_TEST;
                    end
                end
            end
            S_REPORT: begin
                ev[mpt_pkg::IRQ_PASS] = 1'b1;
                n.rep_lo = q.lo;
                n.rep_hi = q.hi;
                n.st     = q.ret;
            end
            S_SEG_END: begin
                // halt mode ends with the range
                if (q.stop_req
                    || (q.seg_hi == q.run_hi && !q.run_cont)) begin
                    ev[mpt_pkg::IRQ_DONE] = 1'b1;
                    n.st = S_IDLE;
                end else if (q.seg_hi == q.run_hi) begin
                    // wrap to the start of the range
                    n.seg_lo = q.run_lo;
                    n.st     = S_SEG;
                end else begin
                    n.seg_lo = q.seg_hi + 1'b1;
                    n.st     = S_SEG;
                end
            end
        endcase

        // Sticky events; a new event beats a clear in the same cycle
        n.irq_stat = (q.irq_stat & ~w1c) | ev;
        n.irq      = |(n.irq_stat & n.irq_mask);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // idle, halt mode, flags clear
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            q          <= '0;
            q.cfg_sel  <= mpt_pkg::CFG_SEL_RST;
            q.cfg_cont <= mpt_pkg::CFG_CONT_RST;
            q.cfg_lo   <= mpt_pkg::RANGE_LO_RST;
            q.cfg_hi   <= mpt_pkg::RANGE_HI_RST;
        end else if (CE_I) begin
            q <= n;
        end
    end

    // Outputs straight from the state flops
    assign PRDATA_O  = q.prdata;
    assign PREADY_O  = q.pready;
    assign PSLVERR_O = q.pslverr;
    assign MEM_REQ_O = q.mem;
    assign IRQ_O     = q.irq;

endmodule

// ### tb/mpt_monitor.sv
/* Port checker for the memory pattern tester.
   Assumes one clock, reset synchronous and active low. */
module mpt_monitor (
    input wire logic              CLK_I,
    input wire logic              RST_N_I,
    input wire logic              PSEL_I,
    input wire logic              PENABLE_I,
    input wire logic              PWRITE_I,
    input wire logic [7:0]        PADDR_I,
    input wire logic [31:0]       PRDATA_O,
    input wire logic              PREADY_O,
    input wire logic              PSLVERR_O,
    input wire mpt_pkg::mem_req_t MEM_REQ_O,
    input wire logic              IRQ_O
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    access_wait_a: assert property (PSEL_I && !PENABLE_I |=>
        !PREADY_O ##1 PREADY_O) else $error("ready not on 2nd access");
    ready_pulse_a: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready longer than one cycle");
    err_ready_a: assert property (PSLVERR_O |-> PREADY_O)
        else $error("error without ready");
    unmapped_err_a: assert property (PREADY_O |->
        PSLVERR_O == (PADDR_I > 8'h20 || PADDR_I[1:0] != 2'h0))
        else $error("bad error flag");
    unmapped_zero_a: assert property (PREADY_O && PSLVERR_O &&
        !PWRITE_I |-> PRDATA_O == 32'h0) else $error("refused read data");
    req_excl_a: assert property (!(MEM_REQ_O.re && MEM_REQ_O.we))
        else $error("read and write together");
    read_space_a: assert property (MEM_REQ_O.re |=>
        !MEM_REQ_O.re [*2]) else $error("reads too close");
    reset_idle_a: assert property ($rose(RST_N_I) |-> (!IRQ_O &&
        !(MEM_REQ_O.re || MEM_REQ_O.we)) [*8]) else $error("busy after reset");
endmodule
bind memory_pattern_tester mpt_monitor mon_u (.CLK_I(CLK_I),
    .RST_N_I(RST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .MEM_REQ_O(MEM_REQ_O),
    .IRQ_O(IRQ_O));

// ### tb/mem_model.sv
/* Word RAM under test, read data one cycle after the request.
   Assumes the tester clock; a fault flips one bit at one address. */
module mem_model (
    input  wire logic              clk_i,
    input  wire mpt_pkg::mem_req_t req_i,
    input  wire logic              fault_i,
    input  wire mpt_pkg::addr_t    fault_addr_i,
    output mpt_pkg::data_t         rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    mpt_pkg::data_t mem_q [65536];
    mpt_pkg::data_t rd_q;
    logic           vld_q;
    // Array and read port; data is inverted outside the answer cycle
    // so a late sample never sees a stale match
    always_ff @(posedge clk_i) begin
        if (req_i.we) mem_q[req_i.addr] <= req_i.wdata;
        vld_q <= req_i.re;
        if (req_i.re) rd_q <= mem_q[req_i.addr] ^ ((fault_i &&
            req_i.addr == fault_addr_i) ? 16'h0040 : 16'h0000);
    end
    assign rdata_o = vld_q ? rd_q : ~rd_q;
endmodule

// ### tb/testbench.sv
/* Self-checking bench: APB master, RAM model, write-stream audit.
   Assumes the tester answers APB with one wait state. */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, ce, psel, penable, pwrite, err_q, pslverr;
    logic pready, irq, fault;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    mpt_pkg::mem_req_t mreq;
    mpt_pkg::data_t mrdata;
    mpt_pkg::addr_t lo, bad_a;
    logic [3:0] sel_q;
    int mismatches, n_tests, nw, nr, bad, n;
    memory_pattern_tester dut_u (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce),
        .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .MEM_REQ_O(mreq),
        .MEM_RDATA_I(mrdata), .IRQ_O(irq));
    mem_model mem_u (.clk_i(clk), .req_i(mreq), .fault_i(fault),
        .fault_addr_i(bad_a), .rdata_o(mrdata));
    always #5 clk = ~clk;
    // ------------------------------------------------------------
    // Tasks and expectations
    // ------------------------------------------------------------
    // Audit every write against the selected test's patterns
    always @(posedge clk) begin
        nr += mreq.re;
        if (mreq.we) begin
            nw++;
            case (sel_q)
                4'h1: bad += (mreq.wdata !== mreq.addr);
                4'h2: bad += !(mreq.wdata inside {mpt_pkg::WORD_VALUE,
                    ~mpt_pkg::WORD_VALUE});
                4'h4: bad += !($onehot(mreq.wdata) || $onehot(~mreq.wdata));
                default: bad += !(mreq.wdata inside {mpt_pkg::GAL_BG_P1,
                    mpt_pkg::GAL_TW_P1});
            endcase
        end
    end
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // Expected memory traffic of one run, per test kind and word count
    function automatic int exp_wr(int i, int k);
        return k * ((i == 0) ? 1 : (i == 2) ? 96 : 6);
    endfunction
    // Galloping: fill check plus a pair per other word, two passes
    function automatic int exp_rd(int i, int k);
        return (i == 3) ? 2 * k * (2 * k - 1) : exp_wr(i, k);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic run(input logic [3:0] s, input logic cont,
                       input logic [31:0] rng);
        apb(1, mpt_pkg::OFF_IRQ_STAT, 32'hf);
        apb(1, mpt_pkg::OFF_CFG, {27'h0, cont, s});
        apb(1, mpt_pkg::OFF_RANGE, rng);
        sel_q = s; nw = 0; nr = 0; bad = 0;
        apb(1, mpt_pkg::OFF_CTRL, 32'h1);
        if (cont) begin
            do apb(0, mpt_pkg::OFF_IRQ_STAT, 0); while (r[0] !== 1'b1);
            apb(1, mpt_pkg::OFF_CTRL, 32'h2);
        end
        do apb(0, mpt_pkg::OFF_STATUS, 0); while (r[0] !== 1'b0);
    endtask
    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        end_of_test();
    end
    // Main sequence
    initial begin
        clk = 0; rst_n = 0; ce = 1; psel = 0; penable = 0; pwrite = 0;
        paddr = 0; pwdata = 0; fault = 0; bad_a = 0; sel_q = 0;
        void'($urandom(66));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        apb(0, mpt_pkg::OFF_CFG, 0); chk(r, 32'hf);
        chk(err_q, 0);
        apb(0, mpt_pkg::OFF_RANGE, 0); chk(r, 32'hffff0000);
        apb(0, mpt_pkg::OFF_STATUS, 0); chk(r, 0);
        apb(0, 8'h24, 0); chk(r, 0);
        chk(err_q, 1);
        apb(0, 8'h02, 0); chk(err_q, 1);
        apb(1, mpt_pkg::OFF_CFG, 32'h10);
        apb(1, mpt_pkg::OFF_RANGE, 32'h00010002);
        apb(0, mpt_pkg::OFF_CFG, 0); chk(r, 32'hf);
        apb(0, mpt_pkg::OFF_RANGE, 0); chk(r, 32'hffff0000);
        apb(0, mpt_pkg::OFF_IRQ_STAT, 0); chk(r[3], 1);
        apb(1, mpt_pkg::OFF_IRQ_MASK, 32'h4);
        // One run per test kind, random short range in one chunk
        for (int i = 0; i < 4; i++) begin
            lo = 16'h1000 | 16'($urandom & 32'h3f0);
            n = 2 + $urandom % 7;
            run(4'h1 << i, 0, {lo + 16'(n - 1), lo});
            chk(bad, 0);
            chk(nw, exp_wr(i, n));
            if (i < 3) chk(nr, exp_rd(i, n));
            else chk(nr, exp_rd(i, n));
            chk(irq, 1);
            apb(0, mpt_pkg::OFF_IRQ_STAT, 0); chk(r[2:0], 3'h5);
            apb(0, mpt_pkg::OFF_REPORT, 0); chk(r, {lo + 16'(n - 1), lo});
        end
        apb(1, mpt_pkg::OFF_IRQ_STAT, 32'hf); chk(irq, 0);
        // Masked error run: galloping background fault, halt mode
        apb(1, mpt_pkg::OFF_IRQ_MASK, 0);
        fault <= 1'b1;
        bad_a <= lo + 16'h2;
        run(4'h8, 0, {lo + 16'h7, lo});
        apb(0, mpt_pkg::OFF_FAIL_ADDR, 0); chk(r, {16'h0, bad_a});
        apb(0, mpt_pkg::OFF_FAIL_DATA, 0);
        chk(r, {mpt_pkg::GAL_BG_P1 ^ 16'h0040, mpt_pkg::GAL_BG_P1});
        apb(0, mpt_pkg::OFF_IRQ_STAT, 0); chk(r[2:1], 2'h3);
        chk(irq, 0);
        fault <= 1'b0;
        // Continuous run over two segments, stopped after a pass
        run(4'h1, 1, 32'h10030ffc);
        apb(0, mpt_pkg::OFF_IRQ_STAT, 0); chk(r[2], 1);
        end_of_test();
    end
endmodule
